/* File: logic/exec_cfg.svh */
// Functional notes
// - move-file copies file register 0..31 unchanged
// - move-file select 0 writes acc, 1 file
// - move-file updates zero flag from moved value
// - literal load sets acc, flags untouched
// - config load copies acc, flags untouched
// - return loads literal, pc from stack top
// - return-with-literal takes two instruction cycles
// - sleep clears watchdog and prescaler, keeps wake
// - sleep sets timeout_n, clears powerdown_n
// - sleep then halts the oscillator
// - rotate-left through carry, only carry changes
// - rotate select 0 writes acc, 1 file
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
// register byte offsets
`define ADDR_INSTR 8'h00
`define ADDR_ACC 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_CONFIG 8'h0C
`define ADDR_PC 8'h10
`define ADDR_STACK_TOP 8'h14
`define ADDR_FILE_IDX 8'h18
`define ADDR_FILE_DATA 8'h1C
`define ADDR_WATCHDOG 8'h20
`define ADDR_CTRL 8'h24
// instruction word fields
`define OP_HI 11
`define OP_LO 8
`define LIT_HI 7
`define DSEL_BIT 5
`define FSEL_HI 4
// status bit positions
`define ST_CARRY 0
`define ST_ZERO 1
`define ST_PDN 2
`define ST_TON 3
`define ST_WAKE 4
`define ST_BUSY 5
`define ST_SLEEP 6
`define ST_ILLEGAL 7
`define CTRL_WAKE 0
// reset values
`define INSTR_RST 12'h000
`define ACC_RST 8'h00
`define CONFIG_RST 8'hFF
`define PC_RST 11'h000
`define FILE_RST 8'h00
`define TON_RST 1'b1
`define PDN_RST 1'b1
// depth and responses
`define FILE_DEPTH 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: logic/exec_pkg.sv */
`default_nettype none
`include "exec_cfg.svh"
package exec_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_exec = 2'b01,
    st_second = 2'b10,
    st_sleep = 2'b11
  } exec_state_e;
  // instruction codes in bits 11:8
  typedef enum logic [3:0] {
    op_nop = 4'h0,
    op_move_file_reg = 4'h1,
    op_load_literal_acc = 4'h2,
    op_load_config = 4'h3,
    op_return_with_literal = 4'h4,
    op_sleep = 4'h5,
    op_rotate_left_carry = 4'h6
  } opcode_e;
  typedef logic [10:0] pc_t;
  // merge write data into old value per byte lane
  function automatic logic [31:0] apply_strobe(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return v;
  endfunction
endpackage
`default_nettype wire

/* File: logic/exec_alu.sv */
`timescale 1ns/1ns
`default_nettype none
module exec_alu (
  // decoded instruction
  input wire logic [3:0] opcode,
  input wire logic [7:0] literal,
  input wire logic dest_file,
  // operands
  input wire logic [7:0] file_value,
  input wire logic [7:0] acc_value,
  input wire logic carry_in,
  // results
  output logic [7:0] result,
  output logic acc_we,
  output logic file_we,
  output logic config_we,
  output logic carry_we,
  output logic carry_out,
  output logic zero_we,
  output logic pc_from_stack,
  output logic enter_sleep,
  output logic illegal
);
  // per-instruction write enables and result
  always_comb begin
    result = file_value;
    acc_we = 1'b0;
    file_we = 1'b0;
    config_we = 1'b0;
    carry_we = 1'b0;
    carry_out = carry_in;
    zero_we = 1'b0;
    pc_from_stack = 1'b0;
    enter_sleep = 1'b0;
    illegal = 1'b0;
    unique case (opcode)
      exec_pkg::op_nop: begin
        result = acc_value;
      end
      exec_pkg::op_move_file_reg: begin
        result = file_value;
        acc_we = !dest_file;
        file_we = dest_file;
        zero_we = 1'b1;
      end
      exec_pkg::op_load_literal_acc: begin
        result = literal;
        acc_we = 1'b1;
      end
      exec_pkg::op_load_config: begin
        result = acc_value;
        config_we = 1'b1;
      end
      exec_pkg::op_return_with_literal: begin
        result = literal;
        acc_we = 1'b1;
        pc_from_stack = 1'b1;
      end
      exec_pkg::op_sleep: begin
        result = acc_value;
        enter_sleep = 1'b1;
      end
      exec_pkg::op_rotate_left_carry: begin
        result = {file_value[6:0], carry_in};
        carry_we = 1'b1;
        carry_out = file_value[7];
        acc_we = !dest_file;
        file_we = dest_file;
      end
      default: begin
        // unknown codes act as no-operation
        result = acc_value;
        illegal = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: logic/move_return_sleep_rotate_exec.sv */
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "exec_cfg.svh"
module move_return_sleep_rotate_exec (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core side
  output logic osc_halt,
  output logic exec_busy,
  output logic [7:0] config_out
);
  // bus holding registers
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // core state
  exec_pkg::exec_state_e state_reg, state_next;
  logic [11:0] instr_reg, instr_next;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] config_reg, config_next;
  logic carry_reg, carry_next;
  logic zero_reg, zero_next;
  logic timeout_flag_n_reg, timeout_flag_n_next;
  logic powerdown_flag_n_reg, powerdown_flag_n_next;
  logic pin_change_wake_flag_reg, pin_change_wake_flag_next;
  logic illegal_reg, illegal_next;
  exec_pkg::pc_t pc_reg, pc_next;
  exec_pkg::pc_t stack_top_reg, stack_top_next;
  logic [4:0] file_idx_reg, file_idx_next;
  logic [7:0] watchdog_counter_reg, watchdog_counter_next;
  logic [7:0] prescaler_reg, prescaler_next;
  // file register array and its write port
  logic [7:0] file_mem [0:`FILE_DEPTH-1];
  logic fwe;
  logic [4:0] fwaddr;
  logic [7:0] fwdata;
  // decoded fields
  logic [3:0] op;
  logic [7:0] lit;
  logic dsel;
  logic [4:0] fsel;
  logic [7:0] file_rd;
  // alu results
  logic [7:0] alu_result;
  logic alu_acc_we, alu_file_we, alu_config_we, alu_carry_we, alu_carry_out;
  logic alu_zero_we, alu_pc_from_stack, alu_enter_sleep, alu_illegal;
  // bus helpers
  logic aw_take, w_take, ar_take, wr_go, wr_ok, wr_block;
  logic [31:0] wr_val;

  assign op = instr_reg[`OP_HI:`OP_LO];
  assign lit = instr_reg[`LIT_HI:0];
  assign dsel = instr_reg[`DSEL_BIT];
  assign fsel = instr_reg[`FSEL_HI:0];
  assign file_rd = file_mem[fsel];

  // address is a known register
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `ADDR_CTRL);
  endfunction

  // software view of a register
  function automatic logic [31:0] reg_value(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    case (a)
      `ADDR_INSTR: v[11:0] = instr_reg;
      `ADDR_ACC: v[7:0] = acc_reg;
      `ADDR_STATUS: begin
        v[`ST_CARRY] = carry_reg;
        v[`ST_ZERO] = zero_reg;
        v[`ST_PDN] = powerdown_flag_n_reg;
        v[`ST_TON] = timeout_flag_n_reg;
        v[`ST_WAKE] = pin_change_wake_flag_reg;
        v[`ST_BUSY] = exec_busy;
        v[`ST_SLEEP] = osc_halt;
        v[`ST_ILLEGAL] = illegal_reg;
      end
      `ADDR_CONFIG: v[7:0] = config_reg;
      `ADDR_PC: v[10:0] = pc_reg;
      `ADDR_STACK_TOP: v[10:0] = stack_top_reg;
      `ADDR_FILE_IDX: v[4:0] = file_idx_reg;
      `ADDR_FILE_DATA: v[7:0] = file_mem[file_idx_reg];
      `ADDR_WATCHDOG: v[15:0] = {prescaler_reg, watchdog_counter_reg};
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  exec_alu u_alu (
    .opcode(op),
    .literal(lit),
    .dest_file(dsel),
    .file_value(file_rd),
    .acc_value(acc_reg),
    .carry_in(carry_reg),
    .result(alu_result),
    .acc_we(alu_acc_we),
    .file_we(alu_file_we),
    .config_we(alu_config_we),
    .carry_we(alu_carry_we),
    .carry_out(alu_carry_out),
    .zero_we(alu_zero_we),
    .pc_from_stack(alu_pc_from_stack),
    .enter_sleep(alu_enter_sleep),
    .illegal(alu_illegal)
  );

  // handshakes, held low while ce is low
  assign awready = ce && !aw_held_reg && !bvalid_reg;
  assign wready = ce && !w_held_reg && !bvalid_reg;
  assign arready = ce && !rvalid_reg;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign ar_take = arvalid && arready;
  assign wr_go = aw_held_reg && w_held_reg;
  // instr only from idle, ctrl always, others not mid-instruction
  assign wr_block = (awaddr_reg == `ADDR_CTRL) ? 1'b0 :
                    (awaddr_reg == `ADDR_INSTR) ? (state_reg != exec_pkg::st_idle) :
                    (state_reg == exec_pkg::st_exec) || (state_reg == exec_pkg::st_second);
  assign wr_ok = wr_go && addr_mapped(awaddr_reg) && !wr_block;
  assign wr_val = exec_pkg::apply_strobe(reg_value(awaddr_reg), wdata_reg, wstrb_reg);

  // outputs
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign osc_halt = (state_reg == exec_pkg::st_sleep);
  assign exec_busy = (state_reg == exec_pkg::st_exec) || (state_reg == exec_pkg::st_second);
  assign config_out = config_reg;

  // bus channel next values
  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (aw_take) begin
      aw_held_next = 1'b1;
      awaddr_next = awaddr;
    end
    if (w_take) begin
      w_held_next = 1'b1;
      wdata_next = wdata;
      wstrb_next = wstrb;
    end
    // both halves present: answer next cycle
    if (wr_go) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (ar_take) begin
      rvalid_next = 1'b1;
      rdata_next = reg_value(araddr);
      rresp_next = addr_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // bus channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (ce) begin
      aw_held_reg <= aw_held_next;
      awaddr_reg <= awaddr_next;
      w_held_reg <= w_held_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // core next values: software writes, then execution
  always_comb begin
    state_next = state_reg;
    instr_next = instr_reg;
    acc_next = acc_reg;
    config_next = config_reg;
    carry_next = carry_reg;
    zero_next = zero_reg;
    timeout_flag_n_next = timeout_flag_n_reg;
    powerdown_flag_n_next = powerdown_flag_n_reg;
    pin_change_wake_flag_next = pin_change_wake_flag_reg;
    illegal_next = illegal_reg;
    pc_next = pc_reg;
    stack_top_next = stack_top_reg;
    file_idx_next = file_idx_reg;
    fwe = 1'b0;
    fwaddr = fsel;
    fwdata = alu_result;
    // watchdog free runs behind its prescaler
    prescaler_next = prescaler_reg + 8'h01;
    watchdog_counter_next = watchdog_counter_reg;
    if (prescaler_reg == 8'hFF) begin
      watchdog_counter_next = watchdog_counter_reg + 8'h01;
    end
    if (wr_ok) begin
      case (awaddr_reg)
        `ADDR_INSTR: begin
          instr_next = wr_val[11:0];
          state_next = exec_pkg::st_exec;
        end
        `ADDR_ACC: acc_next = wr_val[7:0];
        `ADDR_STATUS: begin
          carry_next = wr_val[`ST_CARRY];
          zero_next = wr_val[`ST_ZERO];
          pin_change_wake_flag_next = wr_val[`ST_WAKE];
        end
        `ADDR_PC: pc_next = wr_val[10:0];
        `ADDR_STACK_TOP: stack_top_next = wr_val[10:0];
        `ADDR_FILE_IDX: file_idx_next = wr_val[4:0];
        `ADDR_FILE_DATA: begin
          fwe = 1'b1;
          fwaddr = file_idx_reg;
          fwdata = wr_val[7:0];
        end
        `ADDR_CTRL: begin
          // wake request leaves sleep
          if (wr_val[`CTRL_WAKE] && (state_reg == exec_pkg::st_sleep)) begin
            state_next = exec_pkg::st_idle;
          end
        end
        default: begin
          // read-only registers ignore writes
        end
      endcase
    end
    unique case (state_reg)
      exec_pkg::st_idle: begin
        // waiting for an instruction write
      end
      exec_pkg::st_exec: begin
        if (alu_acc_we) begin
          acc_next = alu_result;
        end
        if (alu_file_we) begin
          fwe = 1'b1;
        end
        if (alu_config_we) begin
          config_next = acc_reg;
        end
        if (alu_carry_we) begin
          carry_next = alu_carry_out;
        end
        if (alu_zero_we) begin
          zero_next = (alu_result == 8'h00);
        end
        illegal_next = alu_illegal;
        pc_next = alu_pc_from_stack ? stack_top_reg : pc_reg + 11'h001;
        if (alu_enter_sleep) begin
          timeout_flag_n_next = 1'b1;
          powerdown_flag_n_next = 1'b0;
          watchdog_counter_next = 8'h00;
          prescaler_next = 8'h00;
          state_next = exec_pkg::st_sleep;
        end else if (alu_pc_from_stack) begin
          state_next = exec_pkg::st_second;
        end else begin
          state_next = exec_pkg::st_idle;
        end
      end
      exec_pkg::st_second: begin
        // second cycle of the return
        state_next = exec_pkg::st_idle;
      end
      exec_pkg::st_sleep: begin
        // oscillator halted until a wake request
      end
    endcase
  end

  // core registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= exec_pkg::st_idle;
      instr_reg <= `INSTR_RST;
      acc_reg <= `ACC_RST;
      config_reg <= `CONFIG_RST;
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
      timeout_flag_n_reg <= `TON_RST;
      powerdown_flag_n_reg <= `PDN_RST;
      pin_change_wake_flag_reg <= 1'b0;
      illegal_reg <= 1'b0;
      pc_reg <= `PC_RST;
      stack_top_reg <= `PC_RST;
      file_idx_reg <= 5'h00;
      watchdog_counter_reg <= 8'h00;
      prescaler_reg <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      acc_reg <= acc_next;
      config_reg <= config_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      timeout_flag_n_reg <= timeout_flag_n_next;
      powerdown_flag_n_reg <= powerdown_flag_n_next;
      pin_change_wake_flag_reg <= pin_change_wake_flag_next;
      illegal_reg <= illegal_next;
      pc_reg <= pc_next;
      stack_top_reg <= stack_top_next;
      file_idx_reg <= file_idx_next;
      watchdog_counter_reg <= watchdog_counter_next;
      prescaler_reg <= prescaler_next;
    end
  end

  // file register array, cleared at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `FILE_DEPTH; i++) begin
        file_mem[i] <= `FILE_RST;
      end
    end else if (ce && fwe) begin
      file_mem[fwaddr] <= fwdata;
    end
  end

  // checks on executed instructions
  logic run;
  logic [7:0] rot_view;
  assign run = ce && (state_reg == exec_pkg::st_exec);
  assign rot_view = {file_rd[6:0], carry_reg};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  move_copy_a: assert property (run && op == exec_pkg::op_move_file_reg && !dsel |=> acc_reg == $past(file_rd))
    else $error("move to acc lost value");
  move_back_a: assert property (run && op == exec_pkg::op_move_file_reg && dsel |=>
    file_rd == $past(file_rd) && acc_reg == $past(acc_reg))
    else $error("move back altered file or acc");
  move_zero_a: assert property (run && op == exec_pkg::op_move_file_reg |=> zero_reg == ($past(file_rd) == 8'h00))
    else $error("move zero flag wrong");
  literal_load_a: assert property (run && op == exec_pkg::op_load_literal_acc |=>
    acc_reg == $past(lit) && $stable(carry_reg) && $stable(zero_reg))
    else $error("literal load wrong");
  config_load_a: assert property (run && op == exec_pkg::op_load_config |=>
    config_out == $past(acc_reg) && $stable(carry_reg) && $stable(zero_reg))
    else $error("config load wrong");
  return_pc_a: assert property (run && op == exec_pkg::op_return_with_literal |=>
    pc_reg == $past(stack_top_reg) && acc_reg == $past(lit) && $stable(zero_reg))
    else $error("return did not reload");
  return_two_a: assert property (run && op == exec_pkg::op_return_with_literal ##1 ce |->
    exec_busy ##1 (state_reg == exec_pkg::st_idle))
    else $error("return not two cycles");
  sleep_watch_a: assert property (run && op == exec_pkg::op_sleep |=>
    watchdog_counter_reg == 8'h00 && prescaler_reg == 8'h00 && $stable(pin_change_wake_flag_reg))
    else $error("sleep watchdog not cleared");
  sleep_status_a: assert property (run && op == exec_pkg::op_sleep |=>
    timeout_flag_n_reg && !powerdown_flag_n_reg)
    else $error("sleep status wrong");
  sleep_halt_a: assert property (run && op == exec_pkg::op_sleep |=> osc_halt && !exec_busy)
    else $error("sleep did not halt");
  rotate_carry_a: assert property (run && op == exec_pkg::op_rotate_left_carry |=>
    carry_reg == $past(file_rd[7]) && $stable(zero_reg))
    else $error("rotate carry wrong");
  rotate_dest_a: assert property (run && op == exec_pkg::op_rotate_left_carry && dsel |=>
    file_rd == $past(rot_view) && $stable(acc_reg))
    else $error("rotate to file wrong");
  rotate_acc_a: assert property (run && op == exec_pkg::op_rotate_left_carry && !dsel |=>
    acc_reg == $past(rot_view))
    else $error("rotate to acc wrong");
  nop_pc_a: assert property (run && op == exec_pkg::op_nop |=>
    pc_reg == $past(pc_reg) + 11'h001 && $stable(acc_reg) && $stable(carry_reg) && $stable(zero_reg))
    else $error("nop changed state");

  return_seen_c: cover property (run && op == exec_pkg::op_return_with_literal ##1 ce ##1 !exec_busy);
  sleep_wake_c: cover property (osc_halt ##[1:20] !osc_halt);
  rotate_file_c: cover property (run && op == exec_pkg::op_rotate_left_carry && dsel);
  move_zero_c: cover property (run && op == exec_pkg::op_move_file_reg ##1 zero_reg);
endmodule
`default_nettype wire

/* File: logic/placeholder_none.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: test/move_return_sleep_rotate_exec_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "exec_cfg.svh"
module move_return_sleep_rotate_exec_tb;
  // clock, reset and bus drive
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid, osc_halt, exec_busy;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] config_out;
  int err_total = 0, compares = 0, busy_cnt = 0;
  // one row: preset acc, file, {zero,carry}, word, then expected values
  typedef struct packed {
    logic [7:0] acc, fil; logic [1:0] st; logic [11:0] ins;
    logic [7:0] e_acc, e_fil; logic [1:0] e_st; logic [10:0] e_pc;
  } row_s;
  row_s rows [9] = '{
    '{8'h11, 8'hA5, 2'b11, 12'h11F, 8'hA5, 8'hA5, 2'b01, 11'h011},
    '{8'h11, 8'h00, 2'b00, 12'h123, 8'h11, 8'h00, 2'b10, 11'h011},
    '{8'h11, 8'h80, 2'b10, 12'h12A, 8'h11, 8'h80, 2'b00, 11'h011},
    '{8'h00, 8'h5C, 2'b11, 12'h2FF, 8'hFF, 8'h5C, 2'b11, 11'h011},
    '{8'h33, 8'h5C, 2'b10, 12'h200, 8'h00, 8'h5C, 2'b10, 11'h011},
    '{8'h00, 8'h81, 2'b10, 12'h607, 8'h02, 8'h81, 2'b11, 11'h011},
    '{8'h00, 8'h40, 2'b01, 12'h627, 8'h00, 8'h81, 2'b00, 11'h011},
    '{8'h00, 8'h77, 2'b11, 12'h45A, 8'h5A, 8'h77, 2'b11, 11'h7F3},
    '{8'h9C, 8'h3C, 2'b01, 12'h000, 8'h9C, 8'h3C, 2'b01, 11'h011}
  };
  // free-running clock
  always #10 aclk = ~aclk;
  // busy cycles, counted off the falling edge
  always @(negedge aclk) begin
    if (exec_busy === 1'b1) busy_cnt++;
  end
  move_return_sleep_rotate_exec dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .osc_halt, .exec_busy, .config_out);
  // verdict and end of run
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bound exceeded on a wait
  task automatic hang();
    err_total++;
    $display("MISMATCH t=%0t wait timed out", $time);
    give_verdict();
  endtask
  // bus write, response kept in resp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // hold each channel until its own ready
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready === 1'b1) ta = 1'b1;
      if (wready === 1'b1) tw = 1'b1;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (++n > 50) hang();
    end
    while (bvalid !== 1'b1) begin
      @(posedge aclk);
      if (++n > 100) hang();
    end
    resp = bresp;
    bready <= 1'b0;
    // let an edge pass so the next call never re-drives bready in this step
    @(posedge aclk);
  endtask
  // bus read into rd
  task automatic rd_bus(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (++n > 50) hang();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) begin
      @(posedge aclk);
      if (++n > 100) hang();
    end
    rd = rdata;
    rready <= 1'b0;
    // let an edge pass so the next call never re-drives rready in this step
    @(posedge aclk);
  endtask
  // read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd_bus(a);
    chk(rd, e);
  endtask
  // launch one word and let it finish
  task automatic ex(input logic [11:0] ins);
    busy_cnt = 0;
    wr(`ADDR_INSTR, {20'h0, ins});
    repeat (3) @(posedge aclk);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({24'h0, config_out}, 32'hFF);
    rd_chk(`ADDR_STATUS, 32'h0C);
    wr(`ADDR_STACK_TOP, 32'h7F3);
    // table of ordinary cases
    for (int i = 0; i < 9; i++) begin
      wr(`ADDR_ACC, {24'h0, rows[i].acc});
      wr(`ADDR_FILE_IDX, {27'h0, rows[i].ins[4:0]});
      wr(`ADDR_FILE_DATA, {24'h0, rows[i].fil});
      wr(`ADDR_STATUS, {30'h0, rows[i].st});
      wr(`ADDR_PC, 32'h10);
      ex(rows[i].ins);
      chk({30'h0, resp}, 32'h0);
      rd_chk(`ADDR_ACC, {24'h0, rows[i].e_acc});
      rd_chk(`ADDR_FILE_DATA, {24'h0, rows[i].e_fil});
      rd_bus(`ADDR_STATUS);
      chk({30'h0, rd[1:0]}, {30'h0, rows[i].e_st});
      rd_chk(`ADDR_PC, {21'h0, rows[i].e_pc});
      chk(32'(busy_cnt), (rows[i].ins[11:8] == 4'h4) ? 32'h2 : 32'h1);
    end
    // configuration load from acc
    wr(`ADDR_ACC, 32'h3C);
    ex(12'h300);
    chk({24'h0, config_out}, 32'h3C);
    // sleep with wake flag set beforehand
    wr(`ADDR_STATUS, 32'h10);
    ex(12'h500);
    rd_bus(`ADDR_WATCHDOG);
    chk(rd & 32'hF0FF, 32'h0);
    chk({31'h0, osc_halt}, 32'h1);
    rd_bus(`ADDR_STATUS);
    chk({27'h0, rd[6:2]}, 32'h16);
    // no launch while asleep, then wake by control write
    wr(`ADDR_INSTR, 32'h2AA);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    wr(`ADDR_CTRL, 32'h1);
    @(posedge aclk);
    chk({31'h0, osc_halt}, 32'h0);
    rd_chk(`ADDR_ACC, 32'h3C);
    // unmapped place and read-only configuration
    wr(8'h28, 32'h0);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    wr(`ADDR_CONFIG, 32'h0);
    chk({24'h0, config_out}, 32'h3C);
    // unknown code: no-operation with the illegal bit raised
    wr(`ADDR_PC, 32'h20);
    ex(12'h7AB);
    rd_bus(`ADDR_STATUS);
    chk({31'h0, rd[7]}, 32'h1);
    rd_chk(`ADDR_PC, 32'h21);
    rd_chk(`ADDR_ACC, 32'h3C);
    // a legal word clears the illegal bit again
    ex(12'h000);
    rd_bus(`ADDR_STATUS);
    chk({31'h0, rd[7]}, 32'h0);
    // clock enable low: handshakes drop and state holds
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({29'h0, awready, wready, arready}, 32'h0);
    chk({24'h0, config_out}, 32'h3C);
    ce <= 1'b1;
    @(posedge aclk);
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({24'h0, config_out}, 32'hFF);
    rd_chk(`ADDR_STATUS, 32'h0C);
    rd_chk(`ADDR_ACC, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
